// ---- hw/pgi2c_codec.sv ----
// Design decision made here: the local read port to the registers.
`timescale 1ns/1ps
`include "pgi2c_cfg.svh"
// Overview of operation
// RQ1 - Host pulses hardware reset low first
// RQ2 - Pages of 128 registers, address zero selects
// RQ3 - Page select steers later accesses
// RQ4 - Two pages, page zero after reset
// RQ5 - Value 0x01 selects page one, 0x00 zero
// RQ6 - Host reads page select back after change
// RQ7 - Seven-bit slave, standard and fast rates
// RQ8 - Answer address 0x18, ignore others
// RQ9 - Never drive SCL nor start transfers
// RQ10 - Master opens with START and address
// RQ11 - SDA changes only while SCL low
// RQ12 - Slave pulls SDA low in ninth clock
// RQ13 - Master acknowledges read bytes for more
// RQ14 - SDA left high means not-acknowledge
// RQ15 - Repeated START restarts address recognition
// RQ16 - Acknowledge general call address zero
// RQ17 - Written bytes go to next addresses
// RQ18 - Acknowledged read continues with next register
// RQ19 - Bus error detector, status and disable
// RQ20 - First written byte sets register pointer
// RQ21 - Page select readable from any page
module pgi2c_codec #(
  parameter int unsigned ERR_TIMEOUT_CYC = `PGI2C_ERR_TIMEOUT_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  pgi2c_if.codec bus,
  input wire logic [7:0] cfg_addr,
  output pgi2c_pkg::pgi2c_byte_t cfg_rdata,
  output logic active_page,
  output logic bus_err,
  output logic busy
);
  import pgi2c_pkg::*;

  // Register space of both pages; index is {page, address}
  pgi2c_byte_t mem [0:255];

  logic [1:0] scl_s;
  logic [1:0] sda_s;
  logic [1:0] rst_s;
  logic scl_q;
  logic sda_q;
  pgi2c_sst_e state;
  pgi2c_kind_e kind;
  logic [3:0] cnt;
  pgi2c_byte_t sh;
  logic [6:0] ptr;
  logic rw;
  logic gc;
  logic sda_oe;
  logic page;
  logic dbg_dis;
  logic err;
  logic [31:0] tmo_cnt;

  wire scl_h;
  wire sda_h;
  wire hw_rst;
  wire scl_rise;
  wire scl_fall;
  wire start_ev;
  wire stop_ev;
  wire byte_end;
  wire addr_hit;
  wire gc_hit;
  wire wr_byte;
  wire page_we;
  wire dbg_we;
  wire mem_we;
  wire quiet;
  wire tmo_hit;
  wire [7:0] dbg_val;
  wire [7:0] rd_byte;

  // Pin synchronisers, then one more stage for edge finding
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_s <= 2'h3;
      sda_s <= 2'h3;
      rst_s <= 2'h3;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else if (ce) begin
      scl_s <= {scl_s[0], bus.scl};
      sda_s <= {sda_s[0], bus.sda};
      rst_s <= {rst_s[0], bus.hw_rst_n};
      scl_q <= scl_s[1];
      sda_q <= sda_s[1];
    end
  end

  // Line events seen on the synchronised levels
  assign scl_h = scl_s[1];
  assign sda_h = sda_s[1];
  assign hw_rst = !rst_s[1]; // RQ1
  assign scl_rise = scl_h && !scl_q;
  assign scl_fall = !scl_h && scl_q;
  assign start_ev = scl_h && scl_q && sda_q && !sda_h; // RQ11
  assign stop_ev = scl_h && scl_q && !sda_q && sda_h; // RQ11

  // Byte decode at the falling edge after the eighth bit
  assign byte_end = (state == S_RX) && scl_fall && (cnt == `PGI2C_BYTE_BITS);
  assign addr_hit = (sh[7:1] == `PGI2C_SLAVE_ADDR); // RQ8
  assign gc_hit = (sh == `PGI2C_GCALL_BYTE); // RQ16
  assign wr_byte = byte_end && (kind == K_DATA) && !gc;
  assign page_we = wr_byte && (ptr == `PGI2C_PAGE_REG); // RQ2
  assign dbg_we = wr_byte && !page && (ptr == `PGI2C_DBG_REG);
  assign mem_we = wr_byte && !page_we && !dbg_we; // RQ3

  // Bus error detector: transfer open with no line activity
  assign quiet = (state != S_IDLE) && !scl_rise && !scl_fall && !start_ev
    && !stop_ev;
  assign tmo_hit = quiet && !dbg_dis
    && (tmo_cnt >= ERR_TIMEOUT_CYC - 32'd1); // RQ19

  // Read data selection, page select visible on both pages
  assign dbg_val = {5'h0, dbg_dis, 1'b0, err};
  assign rd_byte = (ptr == `PGI2C_PAGE_REG) ? {7'h0, page} : // RQ21
    (!page && ptr == `PGI2C_DBG_REG) ? dbg_val : mem[{page, ptr}];

  // Silence timer for the error detector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmo_cnt <= 32'h0;
    end else if (ce) begin
      tmo_cnt <= quiet ? tmo_cnt + 32'd1 : 32'h0;
    end
  end

  // Active page, back to page zero on any reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      page <= `PGI2C_PAGE_RST; // RQ4
    end else if (ce) begin
      if (hw_rst) begin
        page <= `PGI2C_PAGE_RST; // RQ4
      end else if (page_we) begin
        page <= sh[0]; // RQ5
      end
    end
  end

  // Debug register: sticky error status, detector disable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dbg_dis <= 1'b0;
      err <= 1'b0;
    end else if (ce) begin
      if (hw_rst) begin
        dbg_dis <= 1'b0;
        err <= 1'b0;
      end else begin
        if (dbg_we) begin
          dbg_dis <= sh[`PGI2C_DBG_DIS_BIT]; // RQ19
        end
        // Error event wins over a clearing write
        err <= tmo_hit
          || (err && !(dbg_we && !sh[`PGI2C_DBG_ERR_BIT])); // RQ19
      end
    end
  end

  // Register array writes and local read port
  always_ff @(posedge pclk) begin
    if (ce && mem_we) begin
      mem[{page, ptr}] <= sh; // RQ3
    end
    if (ce) begin
      cfg_rdata <= mem[cfg_addr];
    end
  end

  // Slave protocol engine, SDA only ever pulled low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= S_IDLE;
      kind <= K_ADDR;
      cnt <= 4'h0;
      sh <= 8'h00;
      ptr <= 7'h00;
      rw <= 1'b0;
      gc <= 1'b0;
      sda_oe <= 1'b0;
    end else if (ce) begin
      if (hw_rst || stop_ev || tmo_hit) begin
        state <= S_IDLE; // RQ19
        sda_oe <= 1'b0;
      end else if (start_ev) begin
        state <= S_RX; // RQ15
        kind <= K_ADDR;
        cnt <= 4'h0;
        sda_oe <= 1'b0;
      end else begin
        unique case (state)
          S_IDLE: begin
            sda_oe <= 1'b0;
          end
          S_RX: begin
            if (scl_rise) begin
              sh <= {sh[6:0], sda_h}; // RQ7
              cnt <= cnt + 4'd1;
            end else if (byte_end) begin
              cnt <= 4'h0;
              state <= S_ACK;
              sda_oe <= 1'b1; // RQ12
              unique case (kind)
                K_ADDR: begin
                  if (addr_hit || gc_hit) begin
                    rw <= sh[0] && !gc_hit;
                    gc <= gc_hit; // RQ16
                    kind <= K_PTR;
                  end else begin
                    state <= S_IDLE; // RQ8
                    sda_oe <= 1'b0; // RQ14
                  end
                end
                K_PTR: begin
                  if (!gc) begin
                    ptr <= sh[6:0]; // RQ20
                  end
                  kind <= K_DATA;
                end
                default: begin
                  ptr <= ptr + 7'd1; // RQ17
                end
              endcase
            end
          end
          S_ACK: begin
            if (scl_fall && rw) begin
              sh <= rd_byte; // RQ20
              sda_oe <= !rd_byte[7];
              cnt <= 4'd1;
              state <= S_TX;
            end else if (scl_fall) begin
              sda_oe <= 1'b0;
              state <= S_RX;
            end
          end
          S_TX: begin
            if (scl_fall && cnt == `PGI2C_BYTE_BITS) begin
              sda_oe <= 1'b0;
              ptr <= ptr + 7'd1; // RQ18
              state <= S_MACK;
            end else if (scl_fall) begin
              sda_oe <= !sh[6];
              sh <= {sh[6:0], 1'b0};
              cnt <= cnt + 4'd1;
            end
          end
          default: begin
            if (scl_rise) begin
              state <= sda_h ? S_IDLE : S_ACK; // RQ18
            end
          end
        endcase
      end
    end
  end

  // Bus outputs: data line open-drain only, clock never driven
  assign bus.s_sda_o = 1'b0; // RQ9
  assign bus.s_sda_oe = sda_oe;
  assign active_page = page;
  assign bus_err = err;
  assign busy = (state != S_IDLE);

endmodule // pgi2c_codec

// ---- shared/pgi2c_cfg.svh ----
`ifndef PGI2C_CFG_SVH
`define PGI2C_CFG_SVH

// Clock period of pclk
`define PGI2C_CLK_NS 25

// Codec side addressing
`define PGI2C_SLAVE_ADDR 7'h18
`define PGI2C_GCALL_BYTE 8'h00
`define PGI2C_PAGE_REG 7'h00
`define PGI2C_DBG_REG 7'h6b
`define PGI2C_DBG_ERR_BIT 0
`define PGI2C_DBG_DIS_BIT 2
`define PGI2C_PAGE_RST 1'b0
`define PGI2C_BYTE_BITS 4'd8

// Bus error detector: bus stuck without any edge
`define PGI2C_ERR_TIMEOUT_US 1000
`define PGI2C_ERR_TIMEOUT_CYC (`PGI2C_ERR_TIMEOUT_US * 1000 / `PGI2C_CLK_NS)

// Hardware reset pulse from the controller
`define PGI2C_RST_MIN_NS 10
`define PGI2C_RST_CYC \
  ((`PGI2C_RST_MIN_NS + `PGI2C_CLK_NS - 1) / `PGI2C_CLK_NS)

// Quarter of an SCL period, standard mode (100 kHz)
`define PGI2C_QTR_STD_NS 2500
`define PGI2C_QTR_STD_CYC (`PGI2C_QTR_STD_NS / `PGI2C_CLK_NS)

// Controller register offsets (APB byte addresses)
`define PGI2C_REG_CMD 8'h00
`define PGI2C_REG_TXD 8'h04
`define PGI2C_REG_STAT 8'h08
`define PGI2C_REG_RXD 8'h0c
`define PGI2C_REG_QTR 8'h10
`define PGI2C_STAT_BUSY_BIT 0
`define PGI2C_STAT_NACK_BIT 1

`endif

// ---- shared/pgi2c_pkg.sv ----
package pgi2c_pkg;

  typedef logic [7:0] pgi2c_byte_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_RX = 3'b001,
    S_ACK = 3'b010,
    S_TX = 3'b011,
    S_MACK = 3'b100
  } pgi2c_sst_e;

  typedef enum logic [1:0] {
    K_ADDR = 2'b00,
    K_PTR = 2'b01,
    K_DATA = 2'b10
  } pgi2c_kind_e;

  typedef enum logic [2:0] {
    M_IDLE = 3'b000,
    M_START = 3'b001,
    M_BIT = 3'b010,
    M_STOP = 3'b011,
    M_RST = 3'b100
  } pgi2c_mst_e;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_START = 3'b001,
    OP_WRITE = 3'b010,
    OP_RDACK = 3'b011,
    OP_RDNACK = 3'b100,
    OP_STOP = 3'b101,
    OP_RESET = 3'b110
  } pgi2c_op_e;

endpackage

// ---- shared/pgi2c_if.sv ----
`timescale 1ns/1ps
// Open-drain bus wires and codec reset between controller and codec
interface pgi2c_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic hw_rst_n;
  logic scl;
  logic sda;

  // Wired-AND with pull-ups: low only while someone drives low
  assign scl = !(m_scl_oe && !m_scl_o);
  assign sda = !((m_sda_oe && !m_sda_o) || (s_sda_oe && !s_sda_o));

  modport ctrl (
    output m_scl_o, m_scl_oe, m_sda_o, m_sda_oe, hw_rst_n,
    input scl, sda
  );
  modport codec (
    output s_sda_o, s_sda_oe,
    input scl, sda, hw_rst_n
  );
endinterface

// ---- hw/pgi2c_host.sv ----
`timescale 1ns/1ps
`include "pgi2c_cfg.svh"
module pgi2c_host #(
  parameter logic [15:0] QTR_RST = 16'(`PGI2C_QTR_STD_CYC),
  parameter logic [7:0] RST_CYC = 8'(`PGI2C_RST_CYC)
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  pgi2c_if.ctrl bus
);
  import pgi2c_pkg::*;

  logic [1:0] sda_s;
  pgi2c_mst_e state;
  pgi2c_op_e op;
  pgi2c_byte_t txd;
  pgi2c_byte_t rxd;
  pgi2c_byte_t sh;
  logic [15:0] qtr;
  logic [15:0] qcnt;
  logic [1:0] phase;
  logic [3:0] bitn;
  logic [7:0] rst_cnt;
  logic nack;
  logic scl_oe;
  logic sda_oe;
  logic rst_n;

  wire sda_h;
  wire busy;
  wire a_cmd;
  wire a_txd;
  wire a_stat;
  wire a_rxd;
  wire a_qtr;
  wire a_map;
  wire wr_acc;
  wire op_ok;
  wire cmd_we;
  wire tick;
  wire last_bit;
  wire bit_drive;
  wire [31:0] rd_val;

  // APB decode, zero wait states
  assign a_cmd = (paddr == `PGI2C_REG_CMD);
  assign a_txd = (paddr == `PGI2C_REG_TXD);
  assign a_stat = (paddr == `PGI2C_REG_STAT);
  assign a_rxd = (paddr == `PGI2C_REG_RXD);
  assign a_qtr = (paddr == `PGI2C_REG_QTR);
  assign a_map = a_cmd || a_txd || a_stat || a_rxd || a_qtr;
  assign wr_acc = psel && penable && pwrite && a_map;
  assign op_ok = (pwdata[2:0] != 3'h0) && (pwdata[2:0] != 3'h7);
  assign cmd_we = wr_acc && a_cmd && !busy && op_ok;
  assign busy = (state != M_IDLE);
  assign pready = 1'b1;
  assign rd_val = a_cmd ? {29'h0, op} : a_txd ? {24'h0, txd} :
    a_stat ? {30'h0, nack, busy} : a_rxd ? {24'h0, rxd} :
    a_qtr ? {16'h0, qtr} : 32'h0;

  // Bit timing: one tick per quarter SCL period
  assign tick = (qcnt >= qtr - 16'd1);
  assign last_bit = (bitn == `PGI2C_BYTE_BITS);
  assign bit_drive = last_bit ? (op == OP_RDACK) : // RQ13
    (op == OP_WRITE && !sh[7]);
  assign sda_h = sda_s[1];

  // Read data and error captured in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else if (ce && psel && !penable) begin
      prdata <= pwrite ? 32'h0 : rd_val;
      pslverr <= !a_map;
    end
  end

  // Software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txd <= 8'h00;
      qtr <= QTR_RST;
    end else if (ce && wr_acc) begin
      if (a_txd) begin
        txd <= pwdata[7:0];
      end
      if (a_qtr) begin
        qtr <= pwdata[15:0];
      end
    end
  end

  // Data line synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sda_s <= 2'h3;
    end else if (ce) begin
      sda_s <= {sda_s[0], bus.sda};
    end
  end

  // Command sequencer, quarter-period steps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= M_IDLE;
      op <= OP_NONE;
      qcnt <= 16'h0;
      phase <= 2'h0;
      bitn <= 4'h0;
      sh <= 8'h00;
      rxd <= 8'h00;
      nack <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      rst_n <= 1'b1;
      rst_cnt <= 8'h0;
    end else if (ce) begin
      qcnt <= (tick || !busy) ? 16'h0 : qcnt + 16'd1;
      if (cmd_we) begin
        op <= pgi2c_op_e'(pwdata[2:0]);
        phase <= 2'h0;
        bitn <= 4'h0;
        sh <= txd;
        rst_cnt <= 8'h0;
        unique case (pgi2c_op_e'(pwdata[2:0]))
          OP_START: state <= M_START; // RQ10
          OP_STOP: state <= M_STOP;
          OP_RESET: begin
            state <= M_RST;
            rst_n <= 1'b0; // RQ1
          end
          default: state <= M_BIT;
        endcase
      end else if (state == M_RST) begin
        rst_cnt <= rst_cnt + 8'd1;
        if (rst_cnt >= RST_CYC - 8'd1) begin
          rst_n <= 1'b1; // RQ1
          state <= M_IDLE;
        end
      end else if (busy && tick) begin
        phase <= phase + 2'd1;
        unique case (state)
          M_START: begin
            // Release SDA with SCL low, then fall while SCL high
            if (phase == 2'd0) sda_oe <= 1'b0; // RQ11
            if (phase == 2'd1) scl_oe <= 1'b0;
            if (phase == 2'd2) sda_oe <= 1'b1; // RQ11
            if (phase == 2'd3) begin
              scl_oe <= 1'b1;
              state <= M_IDLE;
            end
          end
          M_STOP: begin
            if (phase == 2'd0) sda_oe <= 1'b1;
            if (phase == 2'd1) scl_oe <= 1'b0;
            if (phase == 2'd2) sda_oe <= 1'b0; // RQ11
            if (phase == 2'd3) state <= M_IDLE;
          end
          default: begin
            if (phase == 2'd0) sda_oe <= bit_drive; // RQ11
            if (phase == 2'd1) scl_oe <= 1'b0;
            if (phase == 2'd2 && !last_bit) sh <= {sh[6:0], sda_h};
            if (phase == 2'd2 && last_bit && op == OP_WRITE) begin
              nack <= sda_h; // RQ14
            end
            if (phase == 2'd3) begin
              scl_oe <= 1'b1;
              bitn <= bitn + 4'd1;
              if (last_bit) begin
                state <= M_IDLE;
                if (op != OP_WRITE) rxd <= sh;
              end
            end
          end
        endcase
      end
    end
  end

  // Open-drain drive: SCL and SDA outputs only ever pull low
  assign bus.m_scl_o = 1'b0;
  assign bus.m_scl_oe = scl_oe;
  assign bus.m_sda_o = 1'b0;
  assign bus.m_sda_oe = sda_oe;
  assign bus.hw_rst_n = rst_n;

endmodule // pgi2c_host

// ---- test/pgi2c_checker.sv ----
`timescale 1ns/1ps
module pgi2c_checker #(
  parameter int unsigned ERR_TIMEOUT_CYC = 200
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic m_scl_o,
  input wire logic m_scl_oe,
  input wire logic m_sda_o,
  input wire logic m_sda_oe,
  input wire logic s_sda_o,
  input wire logic s_sda_oe,
  input wire logic hw_rst_n,
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  int unsigned drv_cnt;
  logic scl_q;

  // Cycles the codec holds SDA low with no SCL edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drv_cnt <= 0;
      scl_q <= 1'b1;
    end else begin
      drv_cnt <= (s_sda_oe && scl == scl_q) ? drv_cnt + 1 : 0;
      scl_q <= scl;
    end
  end

  a_open_drain: assert property (
    !m_scl_o && !m_sda_o && !s_sda_o)
    else $error("bus line driven high");
  a_codec_scl_low: assert property (
    $rose(s_sda_oe) |-> !scl && !$past(scl))
    else $error("codec pulled SDA while SCL high");
  a_codec_hold_high: assert property (
    scl && $past(scl) |-> $stable(s_sda_oe))
    else $error("codec moved SDA while SCL high");
  a_rst_pulse: assert property (
    $fell(hw_rst_n) |=> ##[0:3] hw_rst_n)
    else $error("codec reset pulse too long");
  a_scl_high_len: assert property (
    $rose(scl) |-> scl[*8])
    else $error("SCL high phase too short");
  a_drive_limit: assert property (
    drv_cnt <= ERR_TIMEOUT_CYC + 8)
    else $error("stuck SDA not released");
  a_drive_to_clock: assert property (
    $rose(s_sda_oe) |-> s_sda_oe throughout ##[1:600] $rose(scl))
    else $error("codec SDA dropped before clock");
  a_start_only: assert property (
    $rose(m_sda_oe) && scl |-> $past(sda))
    else $error("host SDA fall not a START");
  a_stop_clear: assert property (
    $fell(m_sda_oe) && scl |-> !s_sda_oe)
    else $error("host STOP while codec drives");
endmodule // pgi2c_checker

// ---- test/tb_paged_i2c_control_slave.sv ----
`timescale 1ns/1ps
`include "pgi2c_cfg.svh"
module tb_paged_i2c_control_slave;
  import pgi2c_pkg::*;
  localparam int ERR = 600;
  localparam logic [7:0] wr_addr = {`PGI2C_SLAVE_ADDR, 1'b0};
  localparam logic [7:0] rd_addr = {`PGI2C_SLAVE_ADDR, 1'b1};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [7:0] cfg_addr = 8'h00;
  logic [31:0] prdata;
  logic [31:0] q;
  logic pready, pslverr, slv, active_page, bus_err, busy;
  pgi2c_byte_t cfg_rdata;
  logic scl_q = 1'b1;
  logic [8:0] sh = 9'h0;
  int num_errors = 0;
  int checked = 0;

  pgi2c_if i2c_bus ();

  // Clock
  always #12.5 pclk = ~pclk;

  // Bits seen on the wire at each SCL rise
  always @(posedge pclk) begin
    scl_q <= i2c_bus.scl;
    if (i2c_bus.scl && !scl_q) sh <= {sh[7:0], i2c_bus.sda};
  end

  pgi2c_host i_pgi2c_host (
    .pclk(pclk), .presetn(presetn), .ce(1'b1), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bus(i2c_bus.ctrl));
  pgi2c_codec #(.ERR_TIMEOUT_CYC(ERR)) i_pgi2c_codec (
    .pclk(pclk), .presetn(presetn), .ce(1'b1), .bus(i2c_bus.codec),
    .cfg_addr(cfg_addr), .cfg_rdata(cfg_rdata),
    .active_page(active_page), .bus_err(bus_err), .busy(busy));
  pgi2c_checker #(.ERR_TIMEOUT_CYC(ERR)) i_pgi2c_checker (
    .pclk(pclk), .presetn(presetn),
    .m_scl_o(i2c_bus.m_scl_o), .m_scl_oe(i2c_bus.m_scl_oe),
    .m_sda_o(i2c_bus.m_sda_o), .m_sda_oe(i2c_bus.m_sda_oe),
    .s_sda_o(i2c_bus.s_sda_o), .s_sda_oe(i2c_bus.s_sda_oe),
    .hw_rst_n(i2c_bus.hw_rst_n), .scl(i2c_bus.scl), .sda(i2c_bus.sda));

  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // One APB transfer, entered just after a rising edge
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      num_errors++;
      wrap_up();
    end
    q = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Launch a bus operation and poll until idle
  task automatic op(pgi2c_op_e c);
    int n;
    n = 0;
    apb(1'b1, `PGI2C_REG_CMD, 32'(c));
    do begin
      apb(1'b0, `PGI2C_REG_STAT, 32'h0);
      n++;
    end while (q[`PGI2C_STAT_BUSY_BIT] !== 1'b0 && n < 2000);
    if (q[`PGI2C_STAT_BUSY_BIT] !== 1'b0) begin
      num_errors++;
      wrap_up();
    end
  endtask

  task automatic wb(logic [7:0] b, logic nack);
    apb(1'b1, `PGI2C_REG_TXD, 32'(b));
    op(OP_WRITE);
    apb(1'b0, `PGI2C_REG_STAT, 32'h0);
    chk("nack", 32'(q[`PGI2C_STAT_NACK_BIT]), 32'(nack));
  endtask

  task automatic rb(pgi2c_op_e c, logic [7:0] e);
    op(c);
    apb(1'b0, `PGI2C_REG_RXD, 32'h0);
    chk("rxd", 32'(q[7:0]), 32'(e));
  endtask

  task automatic wreg(logic [7:0] r, logic [7:0] d);
    op(OP_START);
    wb(wr_addr, 1'b0);
    wb(r, 1'b0);
    wb(d, 1'b0);
    op(OP_STOP);
  endtask

  task automatic rreg(logic [7:0] r, logic [7:0] e);
    op(OP_START);
    wb(wr_addr, 1'b0);
    wb(r, 1'b0);
    op(OP_START);
    wb(rd_addr, 1'b0);
    rb(OP_RDNACK, e);
    op(OP_STOP);
  endtask

  task automatic arr(logic [7:0] a, logic [7:0] e);
    cfg_addr <= a;
    repeat (2) @(posedge pclk);
    chk("array", 32'(cfg_rdata), 32'(e));
  endtask

  // Main sequence
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `PGI2C_REG_QTR, 32'h0);
    chk("qtr", q, 32'h64);
    apb(1'b0, 8'h14, 32'h0);
    chk("slverr", 32'(slv), 32'h1);
    chk("unmapped", q, 32'h0);
    apb(1'b1, `PGI2C_REG_CMD, 32'h7);
    apb(1'b0, `PGI2C_REG_CMD, 32'h0);
    chk("cmd", q, 32'h0);
    chk("flags", {30'h0, active_page, bus_err}, 32'h0);
    chk("idle", {30'h0, i2c_bus.scl, i2c_bus.sda}, 32'h3);
    $display("test reset done");
    op(OP_RESET);
    op(OP_START);
    wb(wr_addr, 1'b0);
    chk("wire", 32'(sh), {23'h0, wr_addr, 1'b0});
    wb(8'h05, 1'b0);
    for (int i = 0; i < 3; i++) wb(8'ha1 + 8'(17 * i), 1'b0);
    op(OP_STOP);
    for (int i = 0; i < 3; i++) arr(8'(5 + i), 8'ha1 + 8'(17 * i));
    $display("test write burst done");
    apb(1'b1, `PGI2C_REG_QTR, 32'h19);
    op(OP_START);
    wb(wr_addr, 1'b0);
    wb(8'h05, 1'b0);
    op(OP_START);
    wb(rd_addr, 1'b0);
    rb(OP_RDACK, 8'ha1);
    chk("wire", 32'(sh), 32'h142);
    rb(OP_RDACK, 8'hb2);
    rb(OP_RDNACK, 8'hc3);
    chk("wire", 32'(sh), 32'h187);
    op(OP_STOP);
    $display("test read burst done");
    wreg(8'h00, 8'h01);
    chk("page", 32'(active_page), 32'h1);
    rreg(8'h00, 8'h01);
    wreg(8'h05, 8'h5a);
    arr(8'h85, 8'h5a);
    arr(8'h05, 8'ha1);
    rreg(8'h05, 8'h5a);
    wreg(8'h00, 8'h00);
    rreg(8'h00, 8'h00);
    rreg(8'h05, 8'ha1);
    wreg(8'h00, 8'h01);
    op(OP_RESET);
    chk("page", 32'(active_page), 32'h0);
    rreg(8'h00, 8'h00);
    $display("test pages done");
    op(OP_START);
    wb(8'h32, 1'b1);
    op(OP_STOP);
    op(OP_START);
    wb(`PGI2C_GCALL_BYTE, 1'b0);
    wb(8'h06, 1'b0);
    op(OP_STOP);
    apb(1'b0, `PGI2C_REG_TXD, 32'h0);
    chk("txd", q, 32'h6);
    apb(1'b0, `PGI2C_REG_CMD, 32'h0);
    chk("cmd", q, 32'(OP_STOP));
    $display("test addressing done");
    op(OP_START);
    repeat (ERR + 50) @(posedge pclk);
    chk("bus_err", 32'(bus_err), 32'h1);
    chk("busy", 32'(busy), 32'h0);
    op(OP_STOP);
    rreg(8'h6b, 8'h01);
    wreg(8'h6b, 8'h04);
    chk("bus_err", 32'(bus_err), 32'h0);
    rreg(8'h6b, 8'h04);
    op(OP_START);
    repeat (ERR + 50) @(posedge pclk);
    chk("bus_err", 32'(bus_err), 32'h0);
    chk("busy", 32'(busy), 32'h1);
    op(OP_STOP);
    op(OP_RESET);
    rreg(8'h6b, 8'h00);
    $display("test bus error done");
    wrap_up();
  end
endmodule // tb_paged_i2c_control_slave
